// ==== core/cts_core.sv ====
// ahb-lite register block with bit timing engine and receive frame counter
`timescale 1ns/1ns
`default_nettype none

module cts_core #(
	parameter logic [4:0] MAX_FRAMES = 5'h1f
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// receive path events from the frame logic
	input wire logic frame_stored,
	input wire logic fifo_overflow,
	input wire logic error_detected,
	// bus pin and bit timing results
	input wire logic can_rx,
	output logic bit_start,
	output logic sample_point,
	output logic bit_value,
	output logic error_frame_req,
	// mode and state
	output logic extended_mode,
	output logic bus_off,
	output logic irq
);
	import cts_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] tq_last(input logic [5:0] pre);
		tq_last = {pre, 2'b11};
	endfunction

	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [4:0] addr_idx_ff;
	logic addr_ok_ff;
	logic take;
	logic wr_now;
	logic [7:0] ctrl_ff;
	logic [7:0] timing0_ff;
	logic [7:0] timing1_ff;
	logic [7:0] clk_div_ff;
	logic [8:0] tx_err_ff;
	logic [4:0] rx_count_ff;
	logic [INT_BITS-1:0] int_sts_ff;
	logic [INT_BITS-1:0] int_en_ff;
	logic ovr_pend_ff;
	logic bus_off_ff;
	logic reset_mode;
	logic listen_only;
	logic release_req;
	logic [31:0] rd_mux;

	assign take = hsel & hready & htrans[1];
	assign wr_now = wr_pend_ff & addr_ok_ff;
	assign reset_mode = ctrl_ff[CTRL_RESET_MODE];
	assign listen_only = ctrl_ff[CTRL_LISTEN_ONLY];
	assign release_req = wr_now & (addr_idx_ff == IDX_CMD) & hwdata[CMD_RELEASE];

	// reads take one wait state so that a write just before is seen
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_idx_ff <= 5'h00;
			addr_ok_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= 1'b0;
			if (rd_pend_ff) begin
				rd_pend_ff <= 1'b0;
				hreadyout_ff <= 1'b1;
				hrdata_ff <= rd_mux;
			end else if (take) begin
				addr_idx_ff <= haddr[6:2];
				addr_ok_ff <= (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'b00);
				wr_pend_ff <= hwrite;
				rd_pend_ff <= ~hwrite;
				hreadyout_ff <= hwrite;
			end
		end
	end

	// no buffer start address; no sleep bit in any field
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_ok_ff) begin
			unique case (addr_idx_ff)
				IDX_CTRL: rd_mux = {24'h0, 1'b0, ctrl_ff[6:0] & 7'h03};
				IDX_INT_STS: rd_mux = {28'h0, int_sts_ff};
				IDX_INT_EN: rd_mux = {28'h0, int_en_ff};
				IDX_TIMING0: rd_mux = {24'h0, timing0_ff};
				IDX_TIMING1: rd_mux = {24'h0, timing1_ff};
				IDX_TX_ERR: rd_mux = {23'h0, tx_err_ff};
				IDX_RX_COUNT: rd_mux = {27'h0, rx_count_ff};
				IDX_CLK_DIV: rd_mux = {24'h0, clk_div_ff[CLK_DIV_MODE], 7'h00};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff <= RST_CTRL;
			clk_div_ff <= RST_CLK_DIV;
			timing0_ff <= RST_TIMING0;
			timing1_ff <= RST_TIMING1;
			int_en_ff <= '0;
		end else if (wr_now) begin
			unique case (addr_idx_ff)
				IDX_CTRL: ctrl_ff <= {6'h00, hwdata[1:0]};
				IDX_INT_EN: int_en_ff <= hwdata[INT_BITS-1:0];
				IDX_CLK_DIV: clk_div_ff <= {hwdata[CLK_DIV_MODE], 7'h00};
				IDX_TIMING0: if (reset_mode) timing0_ff <= hwdata[7:0];
				IDX_TIMING1: if (reset_mode) timing1_ff <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			extended_mode <= 1'b0;
		end else begin
			extended_mode <= clk_div_ff[CLK_DIV_MODE];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_err_ff <= 9'h000;
			bus_off_ff <= 1'b0;
		end else if (wr_now && addr_idx_ff == IDX_TX_ERR && reset_mode) begin
			tx_err_ff <= hwdata[8:0];
			bus_off_ff <= clk_div_ff[CLK_DIV_MODE] && (hwdata[8:0] == TX_ERR_BUS_OFF);
		end
	end

	// ----------------------------------------------------------------
	// receive frame counter
	// ----------------------------------------------------------------
	logic do_store;
	logic do_release;
	assign do_store = frame_stored & (rx_count_ff != MAX_FRAMES);
	assign do_release = release_req & (rx_count_ff != 5'h00);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_count_ff <= RST_RX_COUNT;
		end else if (do_store && !do_release) begin
			rx_count_ff <= rx_count_ff + 5'h01;
		end else if (do_release && !do_store) begin
			rx_count_ff <= rx_count_ff - 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovr_pend_ff <= 1'b0;
		end else if (fifo_overflow) begin
			ovr_pend_ff <= 1'b1;
		end else if (rx_count_ff == 5'h00) begin
			ovr_pend_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	logic [INT_BITS-1:0] int_set;
	logic [INT_BITS-1:0] int_clr;
	logic bus_off_d_ff;
	assign int_set = {error_detected, bus_off_ff & ~bus_off_d_ff,
		ovr_pend_ff & ~fifo_overflow & (rx_count_ff == 5'h00), do_store};
	assign int_clr = (wr_now && addr_idx_ff == IDX_INT_CLR) ? hwdata[INT_BITS-1:0] : '0;

	// no clear on read; set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_sts_ff <= '0;
			bus_off_d_ff <= 1'b0;
			bus_off <= 1'b0;
			irq <= 1'b0;
		end else begin
			int_sts_ff <= (int_sts_ff & ~int_clr) | int_set;
			bus_off_d_ff <= bus_off_ff;
			bus_off <= bus_off_ff;
			irq <= |(((int_sts_ff & ~int_clr) | int_set) & int_en_ff);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			error_frame_req <= 1'b0;
		end else begin
			// listen_only deliberately not consulted here
			error_frame_req <= error_detected & ~reset_mode;
		end
	end

	// ----------------------------------------------------------------
	// bit timing engine
	// ----------------------------------------------------------------
	logic rx_meta_ff;
	logic rx_sync_ff;
	logic [7:0] div_cnt_ff;
	logic tq_en;
	logic [4:0] q_pos_ff;
	logic [1:0] hist_ff;
	logic [4:0] seg1_end;
	logic [4:0] bit_last;
	logic [5:0] quantum_prescale;
	assign quantum_prescale = timing0_ff[5:0];
	assign seg1_end = {1'b0, timing1_ff[3:0]} + 5'h01;
	assign bit_last = seg1_end + {2'b00, timing1_ff[6:4]} + 5'h01;
	assign tq_en = ~reset_mode & (div_cnt_ff == tq_last(quantum_prescale));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end else begin
			rx_meta_ff <= can_rx;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || reset_mode) begin
			div_cnt_ff <= 8'h00;
		end else if (tq_en) begin
			div_cnt_ff <= 8'h00;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
		end
	end

	// quanta per bit; jump width stays in timing0 for resync logic outside
	always_ff @(posedge clk) begin
		if (!rst_n || reset_mode) begin
			q_pos_ff <= 5'h00;
			hist_ff <= 2'b11;
		end else if (tq_en) begin
			q_pos_ff <= (q_pos_ff == bit_last) ? 5'h00 : q_pos_ff + 5'h01;
			hist_ff <= {hist_ff[0], rx_sync_ff};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_point <= 1'b0;
			bit_start <= 1'b0;
			bit_value <= 1'b1;
		end else begin
			sample_point <= tq_en && (q_pos_ff == seg1_end);
			bit_start <= tq_en && (q_pos_ff == bit_last);
			if (tq_en && q_pos_ff == seg1_end) begin
				bit_value <= timing1_ff[T1_TRIPLE] ?
					maj3(hist_ff[1], hist_ff[0], rx_sync_ff) : rx_sync_ff;
			end
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// plain clock count since the last bit start, kept apart from the quantum position
	logic [12:0] since_start_ff;
	logic start_seen_ff;
	logic [12:0] quantum_clks;
	assign quantum_clks = {5'h00, quantum_prescale, 2'b00} + 13'h0004;
	always_ff @(posedge clk) begin
		if (!rst_n || reset_mode) begin
			since_start_ff <= 13'h0000;
			start_seen_ff <= 1'b0;
		end else if (bit_start) begin
			since_start_ff <= 13'h0001;
			start_seen_ff <= 1'b1;
		end else begin
			since_start_ff <= since_start_ff + 13'h0001;
		end
	end

	a_rx_count_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_pend_ff && addr_ok_ff && addr_idx_ff == IDX_RX_COUNT
		|=> hrdata[31:5] == 27'h0 && hrdata[4:0] == $past(rx_count_ff))
		else $error("receive counter read wrong");
	a_count_track: assert property (@(posedge clk) disable iff (!rst_n)
		do_store && !do_release |=> rx_count_ff == $past(rx_count_ff) + 5'h01)
		else $error("stored frame not counted");
	a_quantum_gap: assert property (@(posedge clk) disable iff (!rst_n)
		tq_en && $stable(timing0_ff) |=> !tq_en [*3])
		else $error("quantum shorter than four clocks");
	a_sample_place: assert property (@(posedge clk) disable iff (!rst_n)
		sample_point && start_seen_ff
		|-> since_start_ff == quantum_clks * {8'h00, seg1_end + 5'h01})
		else $error("sample point off the segment boundary");
	a_bit_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		bit_start && start_seen_ff
		|-> since_start_ff == quantum_clks * {8'h00, bit_last + 5'h01})
		else $error("bit period length wrong");
	a_ctrl_six_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_pend_ff && addr_idx_ff == IDX_CTRL |=> !hrdata[6])
		else $error("control bit six not zero");
	a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_pend_ff && (addr_idx_ff == IDX_TEST || addr_idx_ff == IDX_OUT_CTRL)
		|=> hrdata == 32'h0)
		else $error("absent register not zero");
	a_overrun_defer: assert property (@(posedge clk) disable iff (!rst_n)
		!int_sts_ff[INT_OVERRUN] && rx_count_ff != 5'h00 |=> !int_sts_ff[INT_OVERRUN])
		else $error("overrun set before fifo read out");
	a_rx_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
		int_sts_ff[INT_RX] && !int_clr[INT_RX] |=> int_sts_ff[INT_RX])
		else $error("receive flag lost without clear");
	a_forced_bus_off: assert property (@(posedge clk) disable iff (!rst_n)
		wr_now && addr_idx_ff == IDX_TX_ERR && reset_mode && extended_mode
		&& hwdata[8:0] == TX_ERR_BUS_OFF |=> ##1 bus_off)
		else $error("bus-off not entered");
	a_listen_err: assert property (@(posedge clk) disable iff (!rst_n)
		error_detected && !reset_mode && listen_only |=> error_frame_req)
		else $error("error frame dropped in listen-only");
	a_mode_follow: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> extended_mode == $past(clk_div_ff[CLK_DIV_MODE]))
		else $error("mode output not following bit 7");
endmodule // cts_core

`default_nettype wire

// ==== core/cts_pkg.sv ====
// constants shared by the bus timing and receive status block
package cts_pkg;
	// register indices; the byte address is four times the index
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_CMD = 5'h01;
	localparam logic [4:0] IDX_INT_STS = 5'h03;
	localparam logic [4:0] IDX_INT_EN = 5'h04;
	localparam logic [4:0] IDX_INT_CLR = 5'h05;
	localparam logic [4:0] IDX_TIMING0 = 5'h06;
	localparam logic [4:0] IDX_TIMING1 = 5'h07;
	localparam logic [4:0] IDX_OUT_CTRL = 5'h08;
	localparam logic [4:0] IDX_TEST = 5'h09;
	localparam logic [4:0] IDX_TX_ERR = 5'h0f;
	localparam logic [4:0] IDX_RX_COUNT = 5'h1d;
	localparam logic [4:0] IDX_CLK_DIV = 5'h1f;
	// field positions
	localparam int CTRL_RESET_MODE = 0;
	localparam int CTRL_LISTEN_ONLY = 1;
	localparam int CMD_RELEASE = 2;
	localparam int CLK_DIV_MODE = 7;
	localparam int T1_TRIPLE = 7;
	localparam int INT_RX = 0;
	localparam int INT_OVERRUN = 1;
	localparam int INT_BUS_OFF = 2;
	localparam int INT_ERROR = 3;
	localparam int INT_BITS = 4;
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h01;
	localparam logic [7:0] RST_TIMING0 = 8'h00;
	localparam logic [7:0] RST_TIMING1 = 8'h00;
	localparam logic [7:0] RST_CLK_DIV = 8'h00;
	localparam logic [4:0] RST_RX_COUNT = 5'h00;
	// clock rate, bus-off error count and transfer type
	localparam int CLK_HZ = 10_000_000;
	localparam logic [8:0] TX_ERR_BUS_OFF = 9'h100;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== testbench/cts_can_node.sv ====
// bus node model that plays a bit pattern onto the controller's receive pin
`timescale 1ns/1ns
`default_nettype none

module cts_can_node (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bit timing from the controller
	input wire logic bit_start,
	// pattern to send, most significant bit first
	input wire logic load,
	input wire logic [7:0] pattern,
	// bus level seen by the controller
	output logic can_rx
);
	logic [7:0] shift_ff;
	logic [3:0] left_ff;
	logic drive_ff;

	// the line idles recessive: the transceiver pulls it high when no node drives it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_ff <= 8'h00;
			left_ff <= 4'h0;
			drive_ff <= 1'b1;
		end else if (load) begin
			shift_ff <= pattern;
			left_ff <= 4'h8;
			drive_ff <= 1'b1;
		end else if (bit_start) begin
			drive_ff <= (left_ff != 4'h0) ? shift_ff[7] : 1'b1;
			shift_ff <= {shift_ff[6:0], 1'b1};
			left_ff <= (left_ff != 4'h0) ? left_ff - 4'h1 : 4'h0;
		end
	end

	assign can_rx = drive_ff;
endmodule // cts_can_node

`default_nettype wire

// ==== testbench/cts_core_bench.sv ====
// self-checking bench for the bus timing and receive status block
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module cts_core_bench;
	import cts_pkg::*;
	// ----
	// signals
	// ----
	logic clk = 1'b0;
	logic rst_n, hsel, hwrite, hreadyout, hresp, frame_stored, fifo_overflow, error_detected;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic can_rx, bit_start, sample_point, bit_value, error_frame_req;
	logic extended_mode, bus_off, irq, load;
	logic [7:0] pattern, t0, t1;
	logic [31:0] zeros [4] = '{32'h20, 32'h24, 32'h78, 32'h80};
	int mismatches = 0;
	int checked = 0;
	int n, s, efr;

	always #50 clk = ~clk;

	cts_core #(.MAX_FRAMES(5'h1f)) i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frame_stored(frame_stored),
		.fifo_overflow(fifo_overflow), .error_detected(error_detected), .can_rx(can_rx),
		.bit_start(bit_start), .sample_point(sample_point), .bit_value(bit_value),
		.error_frame_req(error_frame_req), .extended_mode(extended_mode), .bus_off(bus_off),
		.irq(irq));

	cts_can_node i_node (.clk(clk), .rst_n(rst_n), .bit_start(bit_start), .load(load),
		.pattern(pattern), .can_rx(can_rx));

	// ----
	// tasks
	// ----
	function automatic logic [31:0] adr(input logic [4:0] i);
		return {25'h0, i, 2'h0};
	endfunction

	// entered just after a rising edge; each phase held until hready is sampled high
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic chk_rd(input logic [31:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		bus(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask

	// one-cycle event pulse; counts error frame requests seen afterwards
	task automatic ev(input logic [2:0] m);
		efr = 0;
		{frame_stored, fifo_overflow, error_detected} <= m;
		@(posedge clk);
		{frame_stored, fifo_overflow, error_detected} <= 3'h0;
		repeat (3) begin
			@(posedge clk);
			if (error_frame_req === 1'b1) efr++;
		end
	endtask

	task automatic await_pulse(input logic smp);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((smp ? sample_point : bit_start) !== 1'b1);
	endtask

	task automatic tally_and_finish;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----
	// tests
	// ----
	initial begin
		rst_n = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		{frame_stored, fifo_overflow, error_detected} = 3'h0;
		load = 1'b0;
		pattern = 8'h53;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_rd(adr(IDX_CTRL), 32'h1);
		chk_rd(adr(IDX_RX_COUNT), 32'h0);
		chk_rd(adr(IDX_CLK_DIV), 32'h0);
		`CHK(extended_mode, 1'b0)
		wr(adr(IDX_INT_EN), 32'hf);
		repeat (3) ev(3'b100);
		chk_rd(adr(IDX_RX_COUNT), 32'h3);
		`CHK(irq, 1'b1)
		chk_rd(adr(IDX_INT_STS), 32'h1, 32'h1);
		chk_rd(adr(IDX_INT_STS), 32'h1, 32'h1);
		// overflow with frames still held must wait for the fifo to empty
		ev(3'b010);
		chk_rd(adr(IDX_INT_STS), 32'h0, 32'h2);
		repeat (3) wr(adr(IDX_CMD), 32'h4);
		chk_rd(adr(IDX_RX_COUNT), 32'h0);
		chk_rd(adr(IDX_INT_STS), 32'h2, 32'h2);
		wr(adr(IDX_INT_CLR), 32'hf);
		wr(adr(IDX_INT_EN), 32'h0);
		@(posedge clk);
		`CHK(irq, 1'b0)
		repeat (32) ev(3'b100);
		chk_rd(adr(IDX_RX_COUNT), 32'h1f);
		`CHK(irq, 1'b0)
		repeat (32) wr(adr(IDX_CMD), 32'h4);
		chk_rd(adr(IDX_RX_COUNT), 32'h0);
		foreach (zeros[i]) begin
			wr(zeros[i], 32'hff);
			chk_rd(zeros[i], 32'h0);
			`CHK(hresp, 1'b0)
		end
		wr(adr(IDX_CLK_DIV), 32'hff);
		chk_rd(adr(IDX_CLK_DIV), 32'h80);
		`CHK(extended_mode, 1'b1)
		chk_rd(adr(5'h1e), 32'h0);
		wr(adr(IDX_CTRL), 32'h41);
		chk_rd(adr(IDX_CTRL), 32'h0, 32'h40);
		wr(adr(IDX_CTRL), 32'h1);
		wr(adr(IDX_TX_ERR), {23'h0, TX_ERR_BUS_OFF});
		repeat (3) @(posedge clk);
		`CHK(bus_off, 1'b1)
		chk_rd(adr(IDX_INT_STS), 32'h4, 32'h4);
		wr(adr(IDX_TX_ERR), 32'hff);
		repeat (3) @(posedge clk);
		`CHK(bus_off, 1'b0)
		// segment one of four quanta, segment two of two, prescale 0 then 1
		for (int p = 0; p < 2; p++) begin
			t0 = {2'h1, 5'h0, p[0]};
			t1 = {p[0], 7'h13};
			wr(adr(IDX_CTRL), 32'h1);
			wr(adr(IDX_TIMING0), {24'h0, t0});
			wr(adr(IDX_TIMING1), {24'h0, t1});
			chk_rd(adr(IDX_TIMING0), {24'h0, t0});
			chk_rd(adr(IDX_TIMING1), {24'h0, t1});
			wr(adr(IDX_CTRL), 32'h0);
			await_pulse(1'b0);
			await_pulse(1'b1);
			s = n;
			`CHK(s, 20 * (p + 1))
			await_pulse(1'b0);
			`CHK(n, 8 * (p + 1))
			`CHK(s + n, 28 * (p + 1))
			load <= 1'b1;
			@(posedge clk);
			load <= 1'b0;
			await_pulse(1'b0);
			for (int i = 7; i >= 0; i--) begin
				await_pulse(1'b1);
				repeat (2) @(posedge clk);
				`CHK(bit_value, pattern[i])
				await_pulse(1'b0);
			end
		end
		wr(adr(IDX_CTRL), 32'h2);
		ev(3'b001);
		`CHK(efr, 1)
		chk_rd(adr(IDX_INT_STS), 32'h8, 32'h8);
		wr(adr(IDX_CTRL), 32'h1);
		ev(3'b001);
		`CHK(efr, 0)
		tally_and_finish();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (10000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
endmodule // cts_core_bench

`default_nettype wire
